// ==== verilog/sao_pkg.sv ====
package sao_pkg;

    // ------------------------------------------------------------
    // Formats and modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SAO_FMT_LJ20 = 2'b00,
        SAO_FMT_I2S20 = 2'b01,
        SAO_FMT_RJ16 = 2'b10,
        SAO_FMT_RJ20 = 2'b11
    } sao_fmt_e;

    localparam int SAO_SAMPLE_W = 20;
    localparam int SAO_BITS_HALF = 32;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SAO_CLK_MHZ = 250;
    localparam int SAO_RESET_HOLD_SYSTEM_CLOCK = 1024;
    localparam int SAO_VALID_AFTER_FS = 18436;
    localparam int SAO_DRIFT_LOSS_BCK = 6;
    localparam int SAO_DRIFT_KEEP_BCK = 5;
    // Master bit clock divider: half period in mclk cycles
    localparam logic [7:0] SAO_MST_HALF_DIV = 8'h06;
    localparam logic [5:0] SAO_BCK_PER_LR = 6'h3F;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [SAO_SAMPLE_W-1:0] left;
        logic [SAO_SAMPLE_W-1:0] right;
    } sao_pair_s;

    typedef struct packed {
        logic bit_clock;
        logic word_clock;
        logic frame_valid_strobe;
    } sao_link_s;

endpackage : sao_pkg

// ==== verilog/sao_sync2.sv ====
`timescale 1ns/1ps
module sao_sync2 (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_ff;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            meta_ff <= 1'b0;
            q_o     <= 1'b0;
        end else begin
            meta_ff <= d_i;
            q_o     <= meta_ff;
        end
    end
endmodule : sao_sync2

// ==== verilog/sao_port.sv ====
`timescale 1ns/1ps
// Behaviour
// - Format codes 00,10,11 pick MSB-first layouts
// - Code 01 is I2S; format latched at release
// - Data changes after bit clock falling edge
// - Master changes clocks after falling edge
// - Master bit clock 64x, strobe 2x word
// - Slave shifts first bit, then only while strobe high
// - Drift over 6 bits forces bipolar zero
// - Drift under 5 bits keeps output going
// - Sync loss only in slave mode
// - Filter transient after release or resync
// - Master clocks follow reset like data
// - Bypass low removes dc, high passes it
// - Output zero during reset plus 1024 cycles
module sao_port
    import sao_pkg::*;
(
    input  wire logic                    mclk_i,
    input  wire logic                    rst_i,
    input  wire logic                    reset_n_i,
    input  wire logic                    master_mode_i,
    input  wire logic [1:0]              format_select_i,
    input  wire logic                    hpf_bypass_i,
    input  wire sao_pair_s               sample_i,
    input  wire logic                    sample_valid_i,
    input  wire logic                    bit_clock_i,
    input  wire logic                    word_clock_i,
    input  wire logic                    frame_valid_strobe_i,
    output sao_link_s                    link_o,
    output logic                         link_oe_o,
    output logic                         data_o,
    output logic                         bipolar_zero_output_o,
    output logic                         hpf_bypass_o,
    output logic                         hpf_restart_o,
    output logic                         data_valid_o
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic rstn_s, bck_s, lr_s, fs_s;
    sao_sync2 u_rst (.mclk_i(mclk_i), .rst_i(rst_i), .d_i(reset_n_i),            .q_o(rstn_s));
    sao_sync2 u_bck (.mclk_i(mclk_i), .rst_i(rst_i), .d_i(bit_clock_i),          .q_o(bck_s));
    sao_sync2 u_lr  (.mclk_i(mclk_i), .rst_i(rst_i), .d_i(word_clock_i),         .q_o(lr_s));
    sao_sync2 u_fs  (.mclk_i(mclk_i), .rst_i(rst_i), .d_i(frame_valid_strobe_i), .q_o(fs_s));

    // ------------------------------------------------------------
    // Reset sequence and format capture
    // ------------------------------------------------------------
    logic        rstn_d_ff;
    logic [10:0] hold_cnt_ff;
    logic        in_reset_ff;
    sao_fmt_e    fmt_ff;
    logic [14:0] valid_cnt_ff;
    logic        data_valid_ff;
    logic        mst_ff;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rstn_d_ff   <= 1'b0;
            hold_cnt_ff <= 11'h000;
            in_reset_ff <= 1'b1;
            fmt_ff      <= SAO_FMT_LJ20;
            mst_ff      <= 1'b0;
        end else begin
            rstn_d_ff <= rstn_s;
            if (!rstn_s) begin
                hold_cnt_ff <= 11'h000;
                in_reset_ff <= 1'b1;
            end else if (!rstn_d_ff) begin
                fmt_ff <= sao_fmt_e'(format_select_i);
                mst_ff <= master_mode_i;
            end else if (in_reset_ff) begin
                if (hold_cnt_ff == 11'(SAO_RESET_HOLD_SYSTEM_CLOCK - 1)) begin
                    in_reset_ff <= 1'b0;
                end
                hold_cnt_ff <= hold_cnt_ff + 11'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // Master clock generation
    // ------------------------------------------------------------
    logic [7:0] div_ff;
    logic       bck_m_ff, lr_m_ff, fs_m_ff;
    logic [5:0] bpos_ff;
    logic [5:0] nxt_bpos;
    logic       m_fall;
    logic [4:0] width;
    logic [5:0] start;

    assign m_fall   = mst_ff && !in_reset_ff && bck_m_ff && (div_ff == SAO_MST_HALF_DIV - 8'h01);
    assign nxt_bpos = bpos_ff + 6'h01;

    always_ff @(posedge mclk_i) begin
        if (rst_i || !mst_ff || in_reset_ff) begin
            div_ff   <= 8'h00;
            bck_m_ff <= 1'b0;
            bpos_ff  <= 6'h00;
            lr_m_ff  <= 1'b0;
            fs_m_ff  <= 1'b0;
        end else if (div_ff == SAO_MST_HALF_DIV - 8'h01) begin
            div_ff   <= 8'h00;
            bck_m_ff <= ~bck_m_ff;
            if (bck_m_ff) begin
                bpos_ff <= nxt_bpos;
                lr_m_ff <= nxt_bpos[5];
                // Strobe spans the data slots of the chosen layout
                fs_m_ff <= ({1'b0, nxt_bpos[4:0]} >= start) && ({1'b0, nxt_bpos[4:0]} < start + 6'(width));
            end
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Edge detection on the active link clock
    // ------------------------------------------------------------
    logic bck_d_ff, lr_d_ff, fs_smp_ff, lr_smp_ff, lr_raw_d_ff;
    logic s_rise, s_fall, bfall, lr_edge, lr_now;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            bck_d_ff    <= 1'b0;
            lr_d_ff     <= 1'b0;
            fs_smp_ff   <= 1'b0;
            lr_smp_ff   <= 1'b0;
            lr_raw_d_ff <= 1'b0;
        end else begin
            bck_d_ff    <= bck_s;
            lr_d_ff     <= lr_smp_ff;
            lr_raw_d_ff <= lr_s;
            if (s_rise) begin
                lr_smp_ff <= lr_s;
                fs_smp_ff <= fs_s;
            end
        end
    end

    assign s_rise  = bck_s && !bck_d_ff;
    assign s_fall  = !bck_s && bck_d_ff;
    assign bfall   = mst_ff ? m_fall : s_fall;
    assign lr_edge = mst_ff ? m_fall && (bpos_ff == 6'h1F || bpos_ff == SAO_BCK_PER_LR)
                            : (lr_s != lr_raw_d_ff);
    // Master phase flips on the same edge, so take the coming phase
    assign lr_now  = mst_ff ? (lr_edge ? (bpos_ff == 6'h1F) : lr_m_ff) : lr_s;

    // ------------------------------------------------------------
    // Sync loss detection (slave only)
    // ------------------------------------------------------------
    logic [7:0] bck_cnt_ff;
    logic [7:0] ref_cnt_ff;
    logic       locked_ff, lost_ff, armed_ff;
    logic [7:0] drift;

    assign drift = (bck_cnt_ff > ref_cnt_ff) ? bck_cnt_ff - ref_cnt_ff : ref_cnt_ff - bck_cnt_ff;

    always_ff @(posedge mclk_i) begin
        if (rst_i || mst_ff || in_reset_ff) begin
            bck_cnt_ff <= 8'h00;
            ref_cnt_ff <= 8'h00;
            locked_ff  <= 1'b0;
            lost_ff    <= 1'b0;
            armed_ff   <= 1'b0;
        end else begin
            if (s_rise) begin
                bck_cnt_ff <= bck_cnt_ff + 8'h01;
            end
            if (lr_smp_ff && !lr_d_ff) begin
                bck_cnt_ff <= 8'h00;
                ref_cnt_ff <= bck_cnt_ff;
                // First count after release is partial, so lock one period later
                armed_ff   <= 1'b1;
                locked_ff  <= armed_ff;
                if (locked_ff && drift > 8'(SAO_DRIFT_LOSS_BCK)) begin
                    lost_ff <= 1'b1;
                end else if (drift < 8'(SAO_DRIFT_KEEP_BCK)) begin
                    lost_ff <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Valid data counter
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i || in_reset_ff || lost_ff) begin
            valid_cnt_ff  <= 15'h0000;
            data_valid_ff <= 1'b0;
        end else if (lr_edge && !lr_now && !data_valid_ff) begin
            valid_cnt_ff <= valid_cnt_ff + 15'h0001;
            if (valid_cnt_ff == 15'(SAO_VALID_AFTER_FS - 1)) begin
                data_valid_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Serialiser
    // ------------------------------------------------------------
    sao_pair_s  pair_ff;
    logic [5:0] pos_ff;
    logic [5:0] slot;
    logic       dout_ff;
    logic       zero;
    logic [SAO_SAMPLE_W-1:0] word;

    assign slot   = lr_edge ? 6'h00 : pos_ff + 6'h01;
    assign zero   = in_reset_ff || lost_ff;
    assign word   = lr_now ? pair_ff.right : pair_ff.left;

    always_comb begin
        width = 5'h14;
        start = 6'h00;
        case (fmt_ff)
            SAO_FMT_LJ20:  start = 6'h00;
            SAO_FMT_I2S20: start = 6'h01;
            SAO_FMT_RJ16:  begin
                width = 5'h10;
                start = 6'h10;
            end
            SAO_FMT_RJ20:  start = 6'h0C;
            default:       start = 6'h00;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pair_ff <= '0;
            pos_ff  <= 6'h00;
            dout_ff <= 1'b0;
        end else begin
            if (sample_valid_i) begin
                pair_ff <= sample_i;
            end
            if (lr_edge) begin
                pos_ff <= 6'h00;
            end else if (bfall) begin
                pos_ff <= slot;
            end
            if (zero) begin
                dout_ff <= 1'b0;
            end else if (lr_edge || bfall) begin
                // strobe low stops the shift after the first bit
                if (!mst_ff && !fs_smp_ff && slot != start) begin
                    dout_ff <= 1'b0;
                end else if (slot >= start && slot < start + 6'(width)) begin
                    dout_ff <= word[5'(SAO_SAMPLE_W - 1) - 5'(slot - start)];
                end else begin
                    dout_ff <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic lost_d_ff, rst_d_ff;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            lost_d_ff <= 1'b0;
            rst_d_ff  <= 1'b1;
        end else begin
            lost_d_ff <= lost_ff;
            rst_d_ff  <= in_reset_ff;
        end
    end

    assign hpf_restart_o         = (rst_d_ff && !in_reset_ff) || (lost_d_ff && !lost_ff);
    assign hpf_bypass_o          = hpf_bypass_i;
    assign link_o                = '{bit_clock: bck_m_ff, word_clock: lr_m_ff, frame_valid_strobe: fs_m_ff};
    assign link_oe_o             = mst_ff;
    assign data_o                = dout_ff;
    assign bipolar_zero_output_o = lost_ff;
    assign data_valid_o          = data_valid_ff;
endmodule : sao_port

// ==== dv/sao_port_asserts.sv ====
`timescale 1ns/1ps
module sao_port_asserts
    import sao_pkg::*;
(
    input wire logic      mclk_i,
    input wire logic      rst_i,
    input wire logic      reset_n_i,
    input wire logic      hpf_bypass_i,
    input wire logic      frame_valid_strobe_i,
    input wire sao_link_s link_o,
    input wire logic      link_oe_o,
    input wire logic      data_o,
    input wire logic      bipolar_zero_output_o,
    input wire logic      hpf_bypass_o,
    input wire logic      hpf_restart_o,
    input wire logic      data_valid_o
);
    // ----
    // Cycles since reset release, and since strobe low
    // ----
    logic [10:0] tail_ff;
    logic [3:0]  gap_ff;
    always_ff @(posedge mclk_i) begin
        if (rst_i || !reset_n_i) tail_ff <= 11'h000;
        else if (tail_ff != 11'h7FF) tail_ff <= tail_ff + 11'h001;
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i) gap_ff <= 4'hF;
        else if (frame_valid_strobe_i) gap_ff <= 4'h0;
        else if (gap_ff != 4'hF) gap_ff <= gap_ff + 4'h1;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    chk_reset_zero: assert property (!reset_n_i [*5] |-> !data_o)
        else $error("data while reset held");
    chk_tail_zero: assert property (tail_ff > 11'h004 && tail_ff < 11'h400 |-> !data_o && !data_valid_o)
        else $error("data in reset tail");
    chk_bypass_mirror: assert property (hpf_bypass_o == hpf_bypass_i)
        else $error("bypass not passed on");
    chk_master_sync: assert property (link_oe_o |-> !bipolar_zero_output_o)
        else $error("sync loss in master");
    chk_loss_zero: assert property (bipolar_zero_output_o [*2] |-> !data_o)
        else $error("data while sync lost");
    chk_bck_half: assert property (disable iff (rst_i || !reset_n_i)
        link_oe_o && $rose(link_o.bit_clock) |-> link_o.bit_clock [*6] ##1 !link_o.bit_clock)
        else $error("bit clock half period");
    chk_wc_after_fall: assert property (link_oe_o &&
        $changed({link_o.word_clock, link_o.frame_valid_strobe}) |-> !link_o.bit_clock)
        else $error("word clock moved in high phase");
    chk_strobe_gate: assert property (!link_oe_o && data_o |-> gap_ff < 4'h8)
        else $error("data with strobe low");
    cov_loss: cover property ($rose(bipolar_zero_output_o));
    cov_restart: cover property (hpf_restart_o);
    cov_master: cover property (link_oe_o && $rose(link_o.word_clock));
endmodule : sao_port_asserts

bind sao_port sao_port_asserts u_chk (
    .mclk_i, .rst_i, .reset_n_i, .hpf_bypass_i, .frame_valid_strobe_i, .link_o, .link_oe_o,
    .data_o, .bipolar_zero_output_o, .hpf_bypass_o, .hpf_restart_o, .data_valid_o
);

// ==== dv/sao_ctrl_model.sv ====
`timescale 1ns/1ps
module sao_ctrl_model (
    input  wire logic [1:0] fmt_i,
    input  wire logic [3:0] extra_i,
    input  wire logic       data_i,
    output logic            bit_clock_o,
    output logic            word_clock_o,
    output logic            strobe_o,
    output logic [19:0]     left_o,
    output logic [19:0]     right_o,
    output int              frames_o
);
    // ----
    // Slave-side timing source and receiver
    // ----
    int          st;
    int          ln;
    int          n;
    logic [19:0] sh;
    assign st = fmt_i == 2'b01 ? 1 : fmt_i == 2'b10 ? 16 : fmt_i == 2'b11 ? 12 : 0;
    assign ln = fmt_i == 2'b10 ? 16 : 20;
    initial begin
        {bit_clock_o, word_clock_o, strobe_o, left_o, right_o, sh} = '0;
        frames_o = 0;
        #7;
        forever begin
            for (int h = 0; h < 2; h++) begin
                n = h == 0 ? 32 + int'(extra_i) : 32;
                for (int s = 0; s < n; s++) begin
                    bit_clock_o = 1'b0;
                    word_clock_o = h[0];
                    strobe_o = s >= st && s < st + ln;
                    // period locked to 12 system clocks
                    #24;
                    bit_clock_o = 1'b1;
                    if (strobe_o) sh = {sh[18:0], data_i};
                    #24;
                end
                if (h == 0) left_o = sh;
                else right_o = sh;
            end
            frames_o++;
        end
    end
endmodule : sao_ctrl_model

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
    import sao_pkg::*;
    logic        mclk_i = 1'b0, rst_i = 1'b1, reset_n_i = 1'b0, master_mode_i = 1'b0;
    logic        hpf_bypass_i = 1'b0, sample_valid_i = 1'b0;
    logic [1:0]  format_select_i = 2'b00;
    sao_pair_s   sample_i = '0;
    logic [3:0]  extra = 4'h0;
    logic        bit_clock_i, word_clock_i, frame_valid_strobe_i, link_oe_o, data_o;
    logic        bipolar_zero_output_o, hpf_bypass_o, hpf_restart_o, data_valid_o;
    sao_link_s   link_o, prev;
    logic [19:0] lw, rw, el, er, msh, ml, mr;
    int          frames, mismatches = 0, checks_done = 0, bz_hits = 0, restarts = 0;
    int          nb = 0, ns = 0, nw = 0, i, t, b0, b1;

    sao_port dut (
        .mclk_i, .rst_i, .reset_n_i, .master_mode_i, .format_select_i, .hpf_bypass_i, .sample_i,
        .sample_valid_i, .bit_clock_i, .word_clock_i, .frame_valid_strobe_i, .link_o, .link_oe_o,
        .data_o, .bipolar_zero_output_o, .hpf_bypass_o, .hpf_restart_o, .data_valid_o
    );
    sao_ctrl_model far (
        .fmt_i(format_select_i), .extra_i(extra), .data_i(data_o), .bit_clock_o(bit_clock_i),
        .word_clock_o(word_clock_i), .strobe_o(frame_valid_strobe_i), .left_o(lw), .right_o(rw),
        .frames_o(frames)
    );

    // ----
    // Clock and event counters
    // ----
    initial forever #2 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        sample_valid_i <= ~sample_valid_i;
        prev <= link_o;
        bz_hits <= bz_hits + int'(bipolar_zero_output_o === 1'b1);
        restarts <= restarts + int'(hpf_restart_o === 1'b1);
        nb <= nb + int'((link_o.bit_clock & ~prev.bit_clock) === 1'b1);
        ns <= ns + int'((link_o.frame_valid_strobe & ~prev.frame_valid_strobe) === 1'b1);
        nw <= nw + int'((link_o.word_clock & ~prev.word_clock) === 1'b1);
        // Master receiver: shift on bit clock rise while strobe high
        if (link_o.bit_clock && !prev.bit_clock && link_o.frame_valid_strobe) msh <= {msh[18:0], data_o};
        if (link_o.word_clock && !prev.word_clock) ml <= msh;
        if (!link_o.word_clock && prev.word_clock) mr <= msh;
    end

    task check(input string nm, input logic [19:0] e, input logic [19:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task results;
        if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results
    task restart(input logic [1:0] f, input logic m);
        @(posedge mclk_i);
        reset_n_i <= 1'b0;
        format_select_i <= f;
        master_mode_i <= m;
        repeat (20) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        repeat (1100) @(posedge mclk_i);
    endtask : restart
    task frames_wait(input int k);
        t = frames + k;
        for (i = 0; i < 900 * k && frames < t; i++) @(posedge mclk_i);
        check("frame_count", 20'(t), 20'(frames));
    endtask : frames_wait
    task wc_rise;
        t = nw;
        for (i = 0; i < 2000 && nw == t; i++) @(posedge mclk_i);
        check("word_clock_rise", 20'h0_0001, 20'(nw != t));
    endtask : wc_rise
    task cmp_words(input logic s16);
        check("left_word", s16 ? {4'h0, el[19:4]} : el, s16 ? {4'h0, lw[15:0]} : lw);
        check("right_word", s16 ? {4'h0, er[19:4]} : er, s16 ? {4'h0, rw[15:0]} : rw);
    endtask : cmp_words

    // ----
    // Test sequence
    // ----
    initial begin
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
        for (int f = 0; f < 4; f++) begin
            el = 20'hC_A351 + 20'(f);
            er = 20'h3_5CAE - 20'(f);
            sample_i <= {el, er};
            hpf_bypass_i <= f[0];
            restart(2'(f), 1'b0);
            frames_wait(4);
            cmp_words(f == 2);
        end
        b0 = bz_hits;
        extra <= 4'h4;
        frames_wait(2);
        extra <= 4'h0;
        frames_wait(3);
        check("loss_small_drift", 20'h0_0000, 20'(bz_hits - b0));
        cmp_words(1'b0);
        b1 = restarts;
        extra <= 4'h8;
        frames_wait(1);
        extra <= 4'h0;
        for (i = 0; i < 4000 && bipolar_zero_output_o !== 1'b1; i++) @(posedge mclk_i);
        check("loss_flag", 20'h0_0001, {19'h0_0000, bipolar_zero_output_o});
        for (i = 0; i < 8000 && bipolar_zero_output_o !== 1'b0; i++) @(posedge mclk_i);
        check("resync_flag", 20'h0_0000, {19'h0_0000, bipolar_zero_output_o});
        frames_wait(4);
        check("restart_seen", 20'h0_0001, 20'(restarts > b1));
        cmp_words(1'b0);
        restart(2'b00, 1'b1);
        check("link_enable", 20'h0_0001, {19'h0_0000, link_oe_o});
        wc_rise();
        b0 = nb;
        b1 = ns;
        wc_rise();
        check("bck_per_word", 20'h0_0040, 20'(nb - b0));
        check("strobe_per_word", 20'h0_0002, 20'(ns - b1));
        check("master_left", el, ml);
        check("master_right", er, mr);
        check("valid_before_count", 20'h0_0000, {19'h0_0000, data_valid_o});
        results();
    end

    initial begin
        #200000;
        mismatches++;
        results();
    end
endmodule : tb
